// ===== logic/dac_update_regs.vh
`ifndef DAC_UPDATE_REGS_VH
`define DAC_UPDATE_REGS_VH

// Register word indices; the byte address is four times the index
`define OFS_COMMIT      4'h0
`define OFS_HEALTH      4'h1
`define OFS_CONTROL     4'h2
`define OFS_MODE        4'h3
`define OFS_CONFIG      4'h4
`define OFS_IRQ_STATUS  4'h5
`define OFS_IRQ_MASK    4'h6

// Commit register
`define COMMIT_BIT      0

// Health flags register
`define HF_PRIMED       26
`define HF_UNDERFLOW    25
`define HF_VALID        24
`define HF_SETTLE_B     23
`define HF_SETTLE_A     22
`define HF_BUSY_B       21
`define HF_BUSY_A       20
`define HF_OT_B         19
`define HF_OT_A         18

// Control register
`define CTL_STATUS_REQ  1
`define CTL_AUTO_REFR   2

// Mode register
`define MODE_DMA_LO     0
`define MODE_TRIG_LO    4
`define DMA_SEL_OFF     3'h0
`define TRIG_MANUAL     2'h0

// Interrupt status and mask layout
`define IRQ_COMMIT_DONE 0
`define IRQ_STATUS_DONE 1
`define IRQ_UNDERFLOW   2
`define IRQ_W           3

// Transfer kinds
`define KIND_CONFIG     2'h0
`define KIND_DATA       2'h1
`define KIND_STATUS     2'h2

// FIFO priming level in 32-bit words
`define PRIME_WORDS     8'h04

// Timing
`define CLK_MHZ         200
`define SETTLE_NS       10000
`define SETTLE_CYC      ((`SETTLE_NS * `CLK_MHZ) / 1000)

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== logic/dac_output_update_and_status.v
// Notes on behaviour
// - Writing one to the commit bit records a pending analog output update.
// - Pending commit updates outputs only after all channel data is transferred.
// - Commit bit reads one while pending, clears itself at the output update.
// - Status mirror refreshes only on request, auto refresh, or configuration write.
// - Group flags kept apart: group A channels 1-4, group B channels 5-8.
// - With DMA on, updates wait until FIFO holds four words; primed flag shows it.
// - A commit arriving with DMA on while the primed flag is zero is discarded.
// - Empty FIFO after priming with DMA on sets underflow, forces DMA select 000 and trigger manual 00.
// - Status valid sets once the first converter status read completes.
// - A status request clears status valid; completion of that read sets it.
// - Each group settle flag is one for 10 us after an output update.
// - Each group busy flag is one while a transfer to that converter runs.
// - Each group thermal flag mirrors the alert from the latest status read.
// - The status request bit logs a request and reads back as zero.
// - A status read takes about 2.5 us and may wait behind other transfers.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
module dac_output_update_and_status (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clk_en,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  fifo_level,
  input  wire        chan_data_pending,
  input  wire        xfer_done,
  input  wire        xfer_over_temp,
  output reg         xfer_start,
  output reg  [1:0]  xfer_kind,
  output reg         xfer_group_b,
  output reg  [31:0] config_word,
  output reg         output_update,
  output reg  [2:0]  output_dma_select,
  output reg  [1:0]  output_trigger_source,
  output reg         irq
);

  `include "dac_update_regs.vh"

  localparam ST_IDLE  = 2'h0;
  localparam ST_RUN_A = 2'h1;
  localparam ST_RUN_B = 2'h2;

  localparam [31:0] SETTLE_FULL = `SETTLE_CYC;

  // Merge a write into a stored word under the byte strobes
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg         aw_have_q;
  reg  [3:0]  aw_idx_q;
  reg         w_have_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         commit_q;
  reg         auto_refr_q;
  reg         stat_pend_q;
  reg         cfg_pend_q;
  reg         primed_q;
  reg         underflow_q;
  reg         valid_q;
  reg         ot_a_q;
  reg         ot_b_q;
  reg         ot_a_tmp_q;
  reg  [11:0] settle_a_q;
  reg  [11:0] settle_b_q;
  reg  [1:0]  state_q;
  reg  [1:0]  op_q;
  reg  [`IRQ_W-1:0] irq_st_q;
  reg  [`IRQ_W-1:0] irq_mask_q;

  wire        wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [3:0]  ar_idx  = s_axi_araddr[5:2];
  wire        dma_on  = (output_dma_select != `DMA_SEL_OFF);
  wire        fifo_ok = !dma_on || primed_q;
  wire        idle    = (state_q == ST_IDLE);
  wire        busy_a  = (state_q == ST_RUN_A);
  wire        busy_b  = (state_q == ST_RUN_B);
  wire        wr_mapped = (aw_idx_q <= `OFS_IRQ_MASK);
  wire        wr_commit = wr_go && (aw_idx_q == `OFS_COMMIT) && w_strb_q[0];
  wire        wr_ctl    = wr_go && (aw_idx_q == `OFS_CONTROL) && w_strb_q[0];
  wire        wr_mode   = wr_go && (aw_idx_q == `OFS_MODE) && w_strb_q[0];
  wire        wr_cfg    = wr_go && (aw_idx_q == `OFS_CONFIG);
  wire        wr_irq_st = wr_go && (aw_idx_q == `OFS_IRQ_STATUS) && w_strb_q[0];
  wire        wr_irq_mk = wr_go && (aw_idx_q == `OFS_IRQ_MASK) && w_strb_q[0];
  wire        stat_req_wr = wr_ctl && w_data_q[`CTL_STATUS_REQ];

  // Live underflow: DMA feeding and primed, and the FIFO has run dry
  wire        uf_event  = dma_on && primed_q && (fifo_level == 8'h00);
  wire        stat_done = busy_b && xfer_done && (op_q == `KIND_STATUS);
  wire        do_load   = idle && commit_q && !cfg_pend_q && !chan_data_pending && fifo_ok;

  wire [31:0] health = {5'h00, primed_q, underflow_q, valid_q,
                        (settle_b_q != 12'h000), (settle_a_q != 12'h000),
                        busy_b, busy_a, ot_b_q, ot_a_q, 18'h00000};

  reg  [31:0] rd_val;
  reg         rd_ok;

  always @* begin
    rd_ok  = 1'b1;
    rd_val = 32'h00000000;
    case (ar_idx)
      `OFS_COMMIT:     rd_val = {31'h00000000, commit_q};
      `OFS_HEALTH:     rd_val = health;
      `OFS_CONTROL:    rd_val = {29'h00000000, auto_refr_q, 2'h0};
      `OFS_MODE:       rd_val = {26'h0000000, output_trigger_source, 1'b0,
                                 output_dma_select};
      `OFS_CONFIG:     rd_val = config_word;
      `OFS_IRQ_STATUS: rd_val = {29'h00000000, irq_st_q};
      `OFS_IRQ_MASK:   rd_val = {29'h00000000, irq_mask_q};
      default:         rd_ok  = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_have_q     <= 1'b0;
      aw_idx_q      <= 4'h0;
      w_have_q      <= 1'b0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_awvalid ? 1'b1 :
                       (!aw_have_q && !(s_axi_awvalid && s_axi_awready));
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= (s_axi_awaddr[31:6] == 26'h0000000) ? s_axi_awaddr[5:2] : 4'hf;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= (s_axi_araddr[31:6] == 26'h0000000) ? rd_val : 32'h00000000;
        s_axi_rresp  <= (rd_ok && s_axi_araddr[31:6] == 26'h0000000) ?
                        `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers, FIFO flags and mode forcing

  always @(posedge aclk) begin
    if (!aresetn) begin
      commit_q              <= 1'b0;
      auto_refr_q           <= 1'b0;
      stat_pend_q           <= 1'b0;
      cfg_pend_q            <= 1'b0;
      config_word           <= 32'h00000000;
      output_dma_select     <= `DMA_SEL_OFF;
      output_trigger_source <= `TRIG_MANUAL;
      primed_q              <= 1'b0;
      underflow_q           <= 1'b0;
      irq_mask_q            <= {`IRQ_W{1'b0}};
    end else if (clk_en) begin
      if (wr_commit && w_data_q[`COMMIT_BIT] && fifo_ok) begin
        commit_q <= 1'b1;
      end else if (do_load) begin
        commit_q <= 1'b0;
      end
      if (wr_ctl) begin
        auto_refr_q <= w_data_q[`CTL_AUTO_REFR];
      end
      if (stat_req_wr || (idle && auto_refr_q && !stat_pend_q) ||
          (busy_b && xfer_done && op_q == `KIND_CONFIG)) begin
        stat_pend_q <= 1'b1;
      end else if (idle && stat_pend_q && !cfg_pend_q && !(chan_data_pending && fifo_ok)) begin
        stat_pend_q <= 1'b0;
      end
      if (wr_cfg) begin
        config_word <= merge(config_word, w_data_q, w_strb_q);
        cfg_pend_q  <= 1'b1;
      end else if (idle) begin
        cfg_pend_q <= 1'b0;
      end
      if (uf_event) begin
        output_dma_select     <= `DMA_SEL_OFF;
        output_trigger_source <= `TRIG_MANUAL;
      end else if (wr_mode) begin
        output_dma_select     <= w_data_q[`MODE_DMA_LO +: 3];
        output_trigger_source <= w_data_q[`MODE_TRIG_LO +: 2];
      end
      if (!dma_on) begin
        primed_q <= 1'b0;
      end else if (fifo_level >= `PRIME_WORDS) begin
        primed_q <= 1'b1;
      end
      // underflow until DMA is selected again
      if (uf_event) begin
        underflow_q <= 1'b1;
      end else if (wr_mode && w_data_q[`MODE_DMA_LO +: 3] != `DMA_SEL_OFF) begin
        underflow_q <= 1'b0;
      end
      if (wr_irq_mk) begin
        irq_mask_q <= w_data_q[`IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer: each transfer visits group A then group B

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q       <= ST_IDLE;
      op_q          <= `KIND_CONFIG;
      xfer_start    <= 1'b0;
      xfer_kind     <= `KIND_CONFIG;
      xfer_group_b  <= 1'b0;
      output_update <= 1'b0;
      valid_q       <= 1'b0;
      ot_a_q        <= 1'b0;
      ot_b_q        <= 1'b0;
      ot_a_tmp_q    <= 1'b0;
      settle_a_q    <= 12'h000;
      settle_b_q    <= 12'h000;
    end else if (clk_en) begin
      xfer_start    <= 1'b0;
      output_update <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cfg_pend_q) begin
            op_q       <= `KIND_CONFIG;
            xfer_kind  <= `KIND_CONFIG;
          end else if (chan_data_pending && fifo_ok) begin
            op_q       <= `KIND_DATA;
            xfer_kind  <= `KIND_DATA;
          end else if (stat_pend_q) begin
            op_q       <= `KIND_STATUS;
            xfer_kind  <= `KIND_STATUS;
          end
          if (cfg_pend_q || (chan_data_pending && fifo_ok) || stat_pend_q) begin
            state_q      <= ST_RUN_A;
            xfer_start   <= 1'b1;
            xfer_group_b <= 1'b0;
          end
        end
        ST_RUN_A: begin
          if (xfer_done) begin
            ot_a_tmp_q   <= xfer_over_temp;
            state_q      <= ST_RUN_B;
            xfer_start   <= 1'b1;
            xfer_group_b <= 1'b1;
          end
        end
        ST_RUN_B: begin
          if (xfer_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      if (stat_done) begin
        ot_a_q <= ot_a_tmp_q;
        ot_b_q <= xfer_over_temp;
      end
      if (stat_done) begin
        valid_q <= 1'b1;
      end else if (stat_req_wr) begin
        valid_q <= 1'b0;
      end
      if (do_load) begin
        output_update <= 1'b1;
      end
      if (do_load) begin
        settle_a_q <= SETTLE_FULL[11:0];
        settle_b_q <= SETTLE_FULL[11:0];
      end else begin
        if (settle_a_q != 12'h000) begin
          settle_a_q <= settle_a_q - 12'h001;
        end
        if (settle_b_q != 12'h000) begin
          settle_b_q <= settle_b_q - 12'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky events, set wins over write-one-to-clear

  wire [`IRQ_W-1:0] irq_set = {uf_event, stat_done, do_load};
  wire [`IRQ_W-1:0] irq_clr = wr_irq_st ? w_data_q[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
  wire [`IRQ_W-1:0] irq_nxt = (irq_st_q & ~irq_clr) | irq_set;

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= {`IRQ_W{1'b0}};
      irq      <= 1'b0;
    end else if (clk_en) begin
      irq_st_q <= irq_nxt;
      irq      <= |(irq_nxt & irq_mask_q);
    end
  end

endmodule

// ===== sim/dac_update_checker.sv
`include "dac_update_regs.vh"
module dac_update_checker (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        chan_data_pending,
  input logic        xfer_done,
  input logic        xfer_start,
  input logic [1:0]  xfer_kind,
  input logic        xfer_group_b,
  input logic        output_update
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer missing");
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer missing");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_update_pulse: assert property (output_update |=> !output_update)
    else $error("update not a pulse");
  chk_update_after_data: assert property (output_update |->
    !$past(chan_data_pending)) else $error("update before data sent");
  chk_start_pulse: assert property (xfer_start |=> !xfer_start)
    else $error("start not a pulse");
  chk_group_b_next: assert property (xfer_done && !xfer_group_b |=>
    xfer_start && xfer_group_b) else $error("group b not started");
  chk_kind_stable: assert property (!xfer_start |->
    $stable(xfer_kind) && $stable(xfer_group_b)) else $error("transfer kind moved");
  cov_update: cover property (output_update);
  cov_status: cover property (xfer_start && xfer_kind == `KIND_STATUS);
  cov_config: cover property (xfer_start && xfer_kind == `KIND_CONFIG);
endmodule
bind dac_output_update_and_status dac_update_checker u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .chan_data_pending, .xfer_done,
  .xfer_start, .xfer_kind, .xfer_group_b, .output_update
);

// ===== sim/dac_xfer_model.sv
module dac_xfer_model (
  input  logic        aclk,
  input  logic        aresetn,
  input  logic        xfer_start,
  input  logic        xfer_group_b,
  input  logic [15:0] lat,
  input  logic        ot_a,
  input  logic        ot_b,
  output logic        xfer_done,
  output logic        xfer_over_temp
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 0;
      xfer_done <= 1'b0;
      xfer_over_temp <= 1'b0;
    end else begin
      xfer_done <= 1'b0;
      // Alert is only meaningful with done, so it toggles otherwise
      xfer_over_temp <= ~xfer_over_temp;
      if (xfer_start)
        cnt_q <= int'(lat);
      else if (cnt_q == 1) begin
        cnt_q <= 0;
        xfer_done <= 1'b1;
        xfer_over_temp <= xfer_group_b ? ot_b : ot_a;
      end else if (cnt_q > 1)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule

// ===== sim/test_dac_output_update_and_status.sv
`include "dac_update_regs.vh"
module test_dac_output_update_and_status;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_CMT = `OFS_COMMIT * 4;
  localparam logic [31:0] A_HF = `OFS_HEALTH * 4;
  localparam logic [31:0] A_CTL = `OFS_CONTROL * 4;
  localparam logic [31:0] A_MODE = `OFS_MODE * 4;
  localparam logic [31:0] A_CFG = `OFS_CONFIG * 4;
  localparam logic [31:0] A_IST = `OFS_IRQ_STATUS * 4;
  localparam logic [31:0] A_IMSK = `OFS_IRQ_MASK * 4;
  logic        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, chan_data_pending, xfer_done, xfer_over_temp;
  logic        xfer_start, xfer_group_b, output_update, irq, ot_a, ot_b;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, config_word, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, xfer_kind, output_trigger_source, rr;
  logic [7:0]  fifo_level;
  logic [2:0]  output_dma_select;
  logic [15:0] lat;
  int          n_fail, num_checks, cyc, upd_cyc;
  dac_output_update_and_status u_dut (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fifo_level,
    .chan_data_pending, .xfer_done, .xfer_over_temp, .xfer_start, .xfer_kind,
    .xfer_group_b, .config_word, .output_update, .output_dma_select,
    .output_trigger_source, .irq
  );
  dac_xfer_model u_far (
    .aclk, .aresetn, .xfer_start, .xfer_group_b, .lat, .ot_a, .ot_b, .xfer_done,
    .xfer_over_temp
  );
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (output_update)
      upd_cyc <= cyc;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n > 3000) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    int k;
    k = 0;
    do begin
      rd(a, v);
      k++;
      guard(k);
    end while ((v & m) !== e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} <= '0;
    {s_axi_rready, chan_data_pending, ot_a, ot_b} <= '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, fifo_level} <= '0;
    s_axi_wstrb <= 4'hf;
    clk_en <= 1'b1;
    lat <= 16'h00fa;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(A_CMT, v);
    chk("commit_reset", v, 32'h0);
    rd(A_HF, v);
    chk("health_reset", v, 32'h0);
    rd(32'h40, v);
    chk("unmapped", 32'(rr), 32'(`RESP_SLVERR));
    wr(32'h40, 32'h1);
    chk("wr_unmapped", 32'(rr), 32'(`RESP_SLVERR));
    $display("test reset done");
    ot_a <= 1'b1;
    wr(A_IMSK, 32'h2);
    wr(A_CTL, 32'h2);
    rd(A_CTL, v);
    chk("request_bit", v & 32'h2, 32'h0);
    rd(A_HF, v);
    chk("busy", v & 32'h0130_0000, 32'h0010_0000);
    poll(A_HF, 32'h0100_0000, 32'h0100_0000);
    chk("alerts", v & 32'h000c_0000, 32'h0004_0000);
    chk("irq_on", 32'(irq), 32'h1);
    wr(A_IMSK, 32'h0);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(A_IST, 32'h7);
    wr(A_IMSK, 32'h7);
    ot_a <= 1'b0;
    ot_b <= 1'b1;
    wr(A_CFG, 32'h0000_1234);
    chk("cfg_bresp", 32'(rr), 32'(`RESP_OKAY));
    chk("config_word", config_word, 32'h0000_1234);
    repeat (1200) @(posedge aclk);
    rd(A_HF, v);
    chk("cfg_refresh", v & 32'h013c_0000, 32'h0108_0000);
    chk("irq_status", 32'(irq), 32'h1);
    wr(A_IST, 32'h7);
    chk("irq_cleared", 32'(irq), 32'h0);
    wr(A_CTL, 32'h2);
    rd(A_HF, v);
    chk("valid_cleared", v & 32'h0100_0000, 32'h0);
    poll(A_HF, 32'h0100_0000, 32'h0100_0000);
    wr(A_IST, 32'h7);
    $display("test status done");
    lat <= 16'h0003;
    chan_data_pending <= 1'b1;
    wr(A_CMT, 32'h1);
    repeat (20) @(posedge aclk);
    rd(A_CMT, v);
    chk("commit_pending", v, 32'h1);
    chan_data_pending <= 1'b0;
    poll(A_CMT, 32'h1, 32'h0);
    rd(A_HF, v);
    chk("settling", v & 32'h00c0_0000, 32'h00c0_0000);
    chk("irq_update", 32'(irq), 32'h1);
    wr(A_IST, 32'h7);
    while (cyc < upd_cyc + `SETTLE_CYC - 10)
      @(posedge aclk);
    rd(A_HF, v);
    chk("settle_late", v & 32'h00c0_0000, 32'h00c0_0000);
    repeat (20) @(posedge aclk);
    rd(A_HF, v);
    chk("settled", v & 32'h00c0_0000, 32'h0);
    $display("test commit done");
    ot_a <= 1'b1;
    wr(A_CTL, 32'h4);
    rd(A_CTL, v);
    chk("auto_bit", v, 32'h4);
    poll(A_HF, 32'h000c_0000, 32'h000c_0000);
    wr(A_CTL, 32'h0);
    $display("test auto done");
    fifo_level <= 8'h02;
    wr(A_MODE, 32'h11);
    chk("dma_on", 32'(output_dma_select), 32'h1);
    rd(A_HF, v);
    chk("not_primed", v & 32'h0600_0000, 32'h0);
    wr(A_CMT, 32'h1);
    rd(A_CMT, v);
    chk("commit_dropped", v, 32'h0);
    fifo_level <= `PRIME_WORDS;
    @(posedge aclk);
    rd(A_HF, v);
    chk("primed", v & 32'h0600_0000, 32'h0400_0000);
    fifo_level <= 8'h00;
    repeat (2) @(posedge aclk);
    rd(A_HF, v);
    chk("underflow", v & 32'h0600_0000, 32'h0200_0000);
    chk("mode_forced", 32'({output_dma_select, output_trigger_source}), 32'h0);
    $display("test fifo done");
    print_verdict();
  end
endmodule
